// ==== core/mbg_regs.svh ====
/*
  bus cycle generator constants: reset values, burst geometry, timing.
  assumes inclusion by bare name from the package only; the two ends do not include it.
*/
`ifndef MBG_REGS_SVH
`define MBG_REGS_SVH

// bytes per bus word, step between sequential addresses
`define MBG_WORD_BYTES     32'h0000_0004
// words per sequential run before a forced break
`define MBG_RUN_WORDS      32'h0000_0100
// words per cache line, and byte alignment of a line
`define MBG_LINE_WORDS     8'h04
`define MBG_LINE_BYTES     32'h0000_0010
// reset values of the pipelined bus outputs
`define MBG_RST_MREQ_N     1'b1
`define MBG_RST_DIR_N      1'b0
`define MBG_RST_SIZE_N     1'b1
`define MBG_RST_LOCK       1'b0
// memory end wait states inserted into each memory cycle
`define MBG_WAIT_STATES    4'h0

`endif

// ==== core/mbg_pkg.sv ====
/*
  bus cycle generator types: request kinds and sequencer phases.
  assumes mbg_regs.svh on the include path.
*/
package mbg_pkg;
  `include "mbg_regs.svh"

  // kind of external access asked for by the core side
  typedef enum logic [2:0] {
    MBG_K_UNCACHED,   // uncached read or unbuffered write, single or multiple
    MBG_K_BUFFERED,   // buffered write drained from the write buffer
    MBG_K_LINEFETCH,  // four word cache line fill
    MBG_K_SWAP        // locked read then write to one address
  } mbg_kind_t;

  // sequencer phase of the core end
  typedef enum logic [2:0] {
    MBG_P_IDLE,
    MBG_P_L1,
    MBG_P_L2,
    MBG_P_DATA,
    MBG_P_SWAPW
  } mbg_phase_t;
endpackage : mbg_pkg

// ==== core/mbg_bus_if.sv ====
/*
  external memory bus between the core end and the memory end.
  assumes one clock; the shared data wire is resolved here from the enables.
*/
`timescale 1ns/10ps
interface mbg_bus_if #(
  parameter int AW = 32,
  parameter int DW = 32
);
  logic          mem_request_n;
  logic          sequential_indicator;
  logic [AW-1:0] addr;
  logic          direction_n;
  logic          size_byte_n;
  logic          lock;
  logic          wait_n;
  logic [DW-1:0] cpu_data_o;
  logic          cpu_data_oe;
  logic [DW-1:0] mem_data_o;
  logic          mem_data_oe;
  logic [DW-1:0] data;

  // wire level of the data bus from whichever end drives it
  assign data = cpu_data_oe ? cpu_data_o : (mem_data_oe ? mem_data_o : '0);

  modport cpu (
    output mem_request_n, sequential_indicator, addr, direction_n, size_byte_n, lock,
    output cpu_data_o, cpu_data_oe,
    input  wait_n, data
  );
  modport mem (
    input  mem_request_n, sequential_indicator, addr, direction_n, size_byte_n, lock,
    output wait_n, mem_data_o, mem_data_oe,
    input  data
  );
endinterface : mbg_bus_if

// ==== core/mbg_seq_check.sv ====
/*
  decides whether the next access may follow the last one sequentially.
  assumes the caller only asks while the bus is in a memory cycle run.
*/
`timescale 1ns/10ps
module mbg_seq_check import mbg_pkg::*; #(
  parameter int AW = 32
) (
  // previous access
  input  wire logic          allow,
  input  wire logic [AW-1:0] prev_addr,
  input  wire logic          prev_dir_n,
  input  wire logic          prev_size_n,
  // candidate access
  input  wire logic [AW-1:0] next_addr,
  input  wire logic          next_dir_n,
  input  wire logic          next_size_n,
  // verdict
  output logic               seq
);
  logic [AW-1:0] step;
  logic [AW-1:0] run_mask;
  logic          at_boundary;

  // run breaks where the word index wraps a run of words
  assign step        = AW'(`MBG_WORD_BYTES);
  assign run_mask    = AW'(`MBG_RUN_WORDS * `MBG_WORD_BYTES) - AW'(1);
  assign at_boundary = (next_addr & run_mask) == '0;

  // same type, next word up, not across a boundary
  assign seq = allow && (next_dir_n == prev_dir_n) && (next_size_n == prev_size_n)
             && (next_addr == prev_addr + step) && !at_boundary;
endmodule : mbg_seq_check

// ==== core/mbg_cpu_end.sv ====
/*
  core end of the external memory bus: builds every access from idle
  and memory cycles, with pipelined request, address, direction, size, lock.
  assumes clk is the memory clock; the memory end holds wait_n low to
  stretch the current cycle and changes it only between bus cycles.
*/
// Behaviour
// - all bus timing from memory clock only
// - memory clock edges follow fast clock falls
// - memory may stretch clock phases
// - wait low freezes the current cycle
// - wait changes only while clock low; here wait_n comes from registers and changes just after the rising edge
// - request high idle, low memory cycle
// - request announces the following cycle
// - sequential indicator is inverse of request
// - address given one cycle ahead
// - sequential means same type, next word
// - nonsequential: idle with address, then memory
// - write data held; read sampled at end
// - direction pipelined, constant within a run
// - size pipelined, constant within a run
// - break runs at 256-word boundaries
// - idle cycles keep address, direction, size
// - uncached access: nonsequential then sequential beats
// - each buffered write starts nonsequential
// - linefetch: four aligned words, always word
// - table fetches are word reads first
// - swap: read then write, both nonsequential
// - lock spans swap, drops after write
`timescale 1ns/10ps
module mbg_cpu_end import mbg_pkg::*; #(
  parameter int AW = 32,
  parameter int DW = 32,
  parameter int CW = 8
) (
  // clock and control
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          ce,
  // access requests from the core
  input  wire logic          req_valid,
  output logic               req_ready,
  input  wire mbg_kind_t     req_kind,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [CW-1:0] req_count,
  input  wire logic          req_write,
  input  wire logic          req_byte,
  input  wire logic [1:0]    req_walk,
  input  wire logic [AW-1:0] req_l1_addr,
  input  wire logic [AW-1:0] req_l2_addr,
  // write data, one word per write beat
  input  wire logic          wdata_valid,
  input  wire logic [DW-1:0] wdata,
  output logic               wdata_ready,
  // read data returned
  output logic               rdata_valid,
  output logic [DW-1:0]      rdata,
  output logic               rdata_walk,
  output logic               busy,
  // external bus
  mbg_bus_if.cpu             bus
);
  typedef struct packed {
    mbg_phase_t    phase;
    mbg_kind_t     kind;
    logic [AW-1:0] base;
    logic [CW-1:0] left;
    logic [CW-1:0] cnt;
    logic          wr;
    logic          byte_sz;
    logic [1:0]    walk;
    logic [AW-1:0] l1;
    logic [AW-1:0] l2;
    logic          first;
    logic          mreq_n;
    logic [AW-1:0] addr;
    logic          dir_n;
    logic          size_n;
    logic          lock;
    logic          pend_walk;
    logic [DW-1:0] wbuf;
    logic [DW-1:0] dout;
    logic          cur_mem;
    logic          cur_wr;
    logic          cur_walk;
    logic [DW-1:0] rdata;
    logic          rvalid;
    logic          rwalk;
  } mbg_cpu_state_t;

  mbg_cpu_state_t s;
  mbg_cpu_state_t next_s;

  logic          advance;
  logic          have;
  logic [AW-1:0] b_addr;
  logic          b_wr;
  logic          b_size_n;
  logic          b_lock;
  logic          b_walk;
  logic          seq;
  logic          commit;

  // beats in a phase, used on entry from request and from phase to phase
  function automatic logic [CW-1:0] phase_len(mbg_phase_t p, mbg_kind_t k,
                                              logic [CW-1:0] c);
    logic [CW-1:0] n;
    n = CW'(1);
    if (p == MBG_P_DATA && k == MBG_K_LINEFETCH) begin
      n = CW'(`MBG_LINE_WORDS);
    end else if (p == MBG_P_DATA && k != MBG_K_SWAP && c != '0) begin
      n = c;
    end
    return n;
  endfunction : phase_len

  // the bus moves one cycle only while wait is high
  assign advance = ce && bus.wait_n;

  // properties of the next beat of the current phase
  always_comb begin
    have     = 1'b1;
    b_addr   = s.base;
    b_wr     = s.wr;
    b_size_n = !s.byte_sz;
    b_lock   = 1'b0;
    b_walk   = 1'b0;
    unique case (s.phase)
      MBG_P_IDLE: begin
        have = 1'b0;
      end
      MBG_P_L1: begin
        b_addr   = s.l1;
        b_wr     = 1'b0;
        b_size_n = 1'b1;
        b_walk   = 1'b1;
      end
      MBG_P_L2: begin
        b_addr   = s.l2;
        b_wr     = 1'b0;
        b_size_n = 1'b1;
        b_walk   = 1'b1;
      end
      MBG_P_DATA: begin
        b_lock = s.kind == MBG_K_SWAP;
        if (s.kind == MBG_K_LINEFETCH) begin
          b_wr     = 1'b0;
          b_size_n = 1'b1;
        end else if (s.kind == MBG_K_SWAP) begin
          b_wr = 1'b0;
        end
      end
      MBG_P_SWAPW: begin
        b_wr   = 1'b1;
        b_lock = 1'b1;
      end
    endcase
  end

  // sequential only inside a phase, straight after a memory cycle
  mbg_seq_check #(
    .AW (AW)
  ) u_seq (
    .allow       (!s.first && !s.mreq_n),
    .prev_addr   (s.addr),
    .prev_dir_n  (s.dir_n),
    .prev_size_n (s.size_n),
    .next_addr   (b_addr),
    .next_dir_n  (b_wr),
    .next_size_n (b_size_n),
    .seq         (seq)
  );

  // a write beat waits for its data word; a nonsequential beat first needs
  // an idle cycle that already showed its address, type and lock
  assign commit = have && (!b_wr || wdata_valid)
                && (seq || (s.mreq_n && s.addr == b_addr && s.dir_n == b_wr
                            && s.size_n == b_size_n && s.lock == b_lock));

  // next state of the whole end
  always_comb begin
    next_s        = s;
    next_s.rvalid = 1'b0;
    if (s.phase == MBG_P_IDLE && req_valid) begin
      next_s.kind    = req_kind;
      next_s.cnt     = req_count;
      next_s.wr      = (req_kind == MBG_K_BUFFERED) || (req_kind == MBG_K_UNCACHED && req_write);
      next_s.byte_sz = req_byte && req_kind != MBG_K_LINEFETCH;
      next_s.walk    = req_walk;
      next_s.l1      = req_l1_addr;
      next_s.l2      = req_l2_addr;
      next_s.base    = (req_kind == MBG_K_LINEFETCH) ?
                       (req_addr & ~(AW'(`MBG_LINE_BYTES) - AW'(1))) : req_addr;
      next_s.phase   = (req_walk != 2'b00) ? MBG_P_L1 : MBG_P_DATA;
      next_s.left    = phase_len(next_s.phase, req_kind, req_count);
      next_s.first   = 1'b1;
    end
    if (advance) begin
      // cycle starting now: memory or idle, as announced last cycle
      next_s.cur_mem  = !s.mreq_n;
      next_s.cur_wr   = s.dir_n;
      next_s.cur_walk = s.pend_walk;
      if (!s.mreq_n && s.dir_n) begin
        next_s.dout = s.wbuf;
      end
      // read sampled at the end of a memory read cycle
      if (s.cur_mem && !s.cur_wr) begin
        next_s.rdata  = bus.data;
        next_s.rvalid = 1'b1;
        next_s.rwalk  = s.cur_walk;
      end
      if (commit) begin
        next_s.mreq_n    = 1'b0;
        next_s.addr      = b_addr;
        next_s.dir_n     = b_wr;
        next_s.size_n    = b_size_n;
        next_s.lock      = b_lock;
        next_s.pend_walk = b_walk;
        next_s.first     = 1'b0;
        if (b_wr) begin
          next_s.wbuf = wdata;
        end
        next_s.base = (s.phase == MBG_P_DATA) ? b_addr + AW'(`MBG_WORD_BYTES) : s.base;
        next_s.left = s.left - CW'(1);
        if (s.left == CW'(1)) begin
          next_s.first = 1'b1;
          unique case (s.phase)
            MBG_P_L1:   next_s.phase = (s.walk == 2'b10) ? MBG_P_L2 : MBG_P_DATA;
            MBG_P_L2:   next_s.phase = MBG_P_DATA;
            MBG_P_DATA: next_s.phase = (s.kind == MBG_K_SWAP) ? MBG_P_SWAPW : MBG_P_IDLE;
            default:    next_s.phase = MBG_P_IDLE;
          endcase
          if (s.phase == MBG_P_DATA && s.kind == MBG_K_SWAP) begin
            next_s.base = b_addr;
          end
          next_s.left = phase_len(next_s.phase, s.kind, s.cnt);
        end
      end else begin
        next_s.mreq_n = 1'b1;
        // lock stays over the memory cycle now starting, then drops
        next_s.lock = s.mreq_n ? (have && b_lock) : s.lock;
        if (have) begin
          next_s.addr   = b_addr;
          next_s.dir_n  = b_wr;
          next_s.size_n = b_size_n;
        end
        // with nothing pending, address, direction and size hold
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (srst) begin
      s        <= '0;
      s.phase  <= MBG_P_IDLE;
      s.kind   <= MBG_K_UNCACHED;
      s.mreq_n <= `MBG_RST_MREQ_N;
      s.dir_n  <= `MBG_RST_DIR_N;
      s.size_n <= `MBG_RST_SIZE_N;
      s.lock   <= `MBG_RST_LOCK;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // bus pins
  assign bus.mem_request_n        = s.mreq_n;
  assign bus.sequential_indicator = ~s.mreq_n;
  assign bus.addr                 = s.addr;
  assign bus.direction_n          = s.dir_n;
  assign bus.size_byte_n          = s.size_n;
  assign bus.lock                 = s.lock;
  assign bus.cpu_data_o           = s.dout;
  assign bus.cpu_data_oe          = s.cur_mem && s.cur_wr;

  // core side
  assign req_ready   = s.phase == MBG_P_IDLE;
  assign wdata_ready = advance && commit && b_wr;
  assign rdata_valid = s.rvalid;
  assign rdata       = s.rdata;
  assign rdata_walk  = s.rwalk;
  assign busy        = (s.phase != MBG_P_IDLE) || !s.mreq_n || s.cur_mem;
endmodule : mbg_cpu_end

// ==== core/mbg_mem_end.sv ====
/*
  memory end of the external bus: a word memory that answers each memory
  cycle and may stretch it with wait states.
  assumes the core end announces each cycle one cycle ahead.
*/
`timescale 1ns/10ps
module mbg_mem_end import mbg_pkg::*; #(
  parameter int        AW    = 32,
  parameter int        DW    = 32,
  parameter int        WORDS = 1024,
  parameter logic[3:0] WAITS = `MBG_WAIT_STATES
) (
  // clock and control
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          ce,
  // back door load and peek
  input  wire logic          load_en,
  input  wire logic [AW-1:0] load_addr,
  input  wire logic [DW-1:0] load_data,
  input  wire logic [AW-1:0] peek_addr,
  output logic [DW-1:0]      peek_data,
  // external bus
  mbg_bus_if.mem             bus
);
  localparam int IW = $clog2(WORDS);
  localparam int NL = DW / 8;

  typedef struct packed {
    logic          cur_mem;
    logic          cur_wr;
    logic          cur_byte;
    logic [1:0]    lane;
    logic [IW-1:0] idx;
    logic [3:0]    wcnt;
    logic [DW-1:0] dout;
    logic [DW-1:0] peek;
  } mbg_mem_state_t;

  mbg_mem_state_t s;
  mbg_mem_state_t next_s;
  logic [DW-1:0]  mem [WORDS];
  logic           advance;

  // stretch each memory cycle by the wait count
  assign bus.wait_n = !(s.cur_mem && s.wcnt != WAITS);
  assign advance    = ce && bus.wait_n;

  // next state: latch the announced cycle, count waits
  always_comb begin
    next_s      = s;
    next_s.peek = mem[peek_addr[IW+1:2]];
    if (!bus.wait_n) begin
      next_s.wcnt = s.wcnt + 4'h1;
    end
    if (advance) begin
      next_s.cur_mem  = !bus.mem_request_n;
      next_s.cur_wr   = bus.direction_n;
      next_s.cur_byte = !bus.size_byte_n;
      next_s.lane     = bus.addr[1:0];
      next_s.idx      = bus.addr[IW+1:2];
      next_s.wcnt     = 4'h0;
      next_s.dout     = mem[bus.addr[IW+1:2]];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // write lanes at the end of a memory write cycle, one process for the array
  always_ff @(posedge clk) begin
    for (int g = 0; g < NL; g++) begin
      if (load_en) begin
        mem[load_addr[IW+1:2]][g*8 +: 8] <= load_data[g*8 +: 8];
      end else if (advance && !srst && s.cur_mem && s.cur_wr
                   && (!s.cur_byte || s.lane == 2'(g))) begin
        mem[s.idx][g*8 +: 8] <= bus.data[g*8 +: 8];
      end
    end
  end

  assign bus.mem_data_o  = s.dout;
  assign bus.mem_data_oe = s.cur_mem && !s.cur_wr;
  assign peek_data       = s.peek;
endmodule : mbg_mem_end

// ==== verification/mbg_assertions.sv ====
/*
  bus rule checker beside the link of core end and memory end.
  assumes one clock, ce held high, inputs taken from mbg_bus_if.
*/
`timescale 1ns/10ps
module mbg_assertions #(
  parameter int WAITS = 1
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // pipelined bus outputs
  input wire logic        mem_request_n,
  input wire logic        sequential_indicator,
  input wire logic [31:0] addr,
  input wire logic        direction_n,
  input wire logic        size_byte_n,
  input wire logic        lock,
  // stretch and data drivers
  input wire logic        wait_n,
  input wire logic        cpu_data_oe,
  input wire logic        mem_data_oe
);
  logic        p_mreq_n;
  logic [31:0] p_addr;
  logic        p_dir_n;
  logic        p_size_n;
  logic [3:0]  wcnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // announcement held at the last advancing edge, and wait length
  always_ff @(posedge clk) begin
    if (srst) begin
      p_mreq_n <= 1'b1;
      p_addr   <= 32'h0;
      p_dir_n  <= 1'b0;
      p_size_n <= 1'b1;
    end else if (wait_n) begin
      p_mreq_n <= mem_request_n;
      p_addr   <= addr;
      p_dir_n  <= direction_n;
      p_size_n <= size_byte_n;
    end
    wcnt <= (srst || wait_n) ? 4'h0 : wcnt + 4'h1;
  end

  // memory cycle announced right after another, or after an idle
  sequence s_seq_adv;
    wait_n && !mem_request_n && !p_mreq_n;
  endsequence
  sequence s_ns_adv;
    wait_n && !mem_request_n && p_mreq_n;
  endsequence

  a_seq_inverse: assert property (sequential_indicator == !mem_request_n)
    else $error("sequential indicator not inverse of request");
  a_wait_freeze: assert property (!wait_n |=>
    $stable({mem_request_n, addr, direction_n, size_byte_n, lock}))
    else $error("bus moved while stretched");
  a_wait_len: assert property (!wait_n |-> wcnt < WAITS)
    else $error("stretch too long");
  a_seq_step: assert property (s_seq_adv |-> addr == p_addr + 32'h4
    && direction_n == p_dir_n && size_byte_n == p_size_n)
    else $error("sequential beat not next word of same type");
  a_run_break: assert property (s_seq_adv |-> addr[9:0] != 10'h000)
    else $error("run not broken at boundary");
  a_nonseq_addr: assert property (s_ns_adv |-> addr == p_addr
    && direction_n == p_dir_n && size_byte_n == p_size_n)
    else $error("address not held through idle");
  a_lock_rise: assert property ($rose(lock) |-> !direction_n && mem_request_n)
    else $error("lock rose off a swap read start");
  a_lock_fall: assert property ($fell(lock) |-> $past(cpu_data_oe))
    else $error("lock fell away from swap write end");
  a_bus_contend: assert property (!(cpu_data_oe && mem_data_oe))
    else $error("both ends drive data");
  a_cpu_drive: assert property (cpu_data_oe |-> !p_mreq_n && p_dir_n)
    else $error("core drives data outside a write cycle");
  a_mem_drive: assert property (mem_data_oe |-> !p_mreq_n && !p_dir_n)
    else $error("memory drives data outside a read cycle");
endmodule : mbg_assertions

// ==== verification/tb.sv ====
/*
  self-checking bench: both bus ends joined, random accesses against a word model.
  assumes the core files compiled first; ce held high on both ends.
*/
`timescale 1ns/10ps
module tb import mbg_pkg::*;;
  logic        clk, srst, req_valid, req_ready, req_write, req_byte, busy, load_en;
  logic        wdata_valid, wdata_ready, rdata_valid, rdata_walk, w_take;
  mbg_kind_t   req_kind;
  logic [31:0] req_addr, req_l1_addr, req_l2_addr, wdata, rdata;
  logic [31:0] load_addr, load_data, peek_addr, peek_data;
  logic [7:0]  req_count;
  logic [1:0]  req_walk;
  logic [31:0] mdl [0:1023];
  logic [32:0] exp_q [$];
  logic [31:0] wq [$];
  int          bad_count, n_compared, cyc;

  mbg_bus_if bus ();
  mbg_cpu_end i_mbg_cpu_end (.clk(clk), .srst(srst), .ce(1'b1), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_addr(req_addr), .req_count(req_count),
    .req_write(req_write), .req_byte(req_byte), .req_walk(req_walk),
    .req_l1_addr(req_l1_addr), .req_l2_addr(req_l2_addr), .wdata_valid(wdata_valid),
    .wdata(wdata), .wdata_ready(wdata_ready), .rdata_valid(rdata_valid), .rdata(rdata),
    .rdata_walk(rdata_walk), .busy(busy), .bus(bus));
  mbg_mem_end #(.WAITS(4'h1)) i_mbg_mem_end (.clk(clk), .srst(srst), .ce(1'b1),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data),
    .peek_addr(peek_addr), .peek_data(peek_data), .bus(bus));
  mbg_assertions #(.WAITS(1)) i_mbg_assertions (.clk(clk), .srst(srst),
    .mem_request_n(bus.mem_request_n), .sequential_indicator(bus.sequential_indicator),
    .addr(bus.addr), .direction_n(bus.direction_n), .size_byte_n(bus.size_byte_n),
    .lock(bus.lock), .wait_n(bus.wait_n), .cpu_data_oe(bus.cpu_data_oe),
    .mem_data_oe(bus.mem_data_oe));

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [32:0] got, input logic [32:0] e);
    n_compared++;
    if (got !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk

  task automatic chk_read(input logic [32:0] got);
    logic [32:0] e;
    e = 'x;
    if (exp_q.size() > 0)
      e = exp_q.pop_front();
    chk(got, e);
  endtask : chk_read

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  // write data feed with random stalls
  always @(negedge clk) w_take = wdata_valid && wdata_ready;
  always @(posedge clk) begin
    if (w_take)
      void'(wq.pop_front());
    wdata_valid <= (wq.size() > 0) && ($urandom % 4 != 0);
    wdata <= (wq.size() > 0) ? wq[0] : ~wdata;
  end

  // read words in issue order
  always @(negedge clk) if (rdata_valid) chk_read({rdata_walk, rdata});

  task automatic issue(input mbg_kind_t k, input logic [31:0] a, input int n,
                       input logic w, input logic b, input logic [1:0] wk);
    logic [31:0] ad, d, l1, l2;
    int t, nb;
    t = 0;
    nb = (k == MBG_K_LINEFETCH) ? 4 : (k == MBG_K_SWAP || n == 0) ? 1 : n;
    l1 = $urandom % 32'hF00 & ~32'h3;
    l2 = $urandom % 32'hF00 & ~32'h3;
    @(negedge clk);
    while (!req_ready && t < 3000) begin
      @(negedge clk);
      t++;
    end
    if (wk != 2'h0)
      exp_q.push_back({1'b1, mdl[l1[11:2]]});
    if (wk == 2'h2)
      exp_q.push_back({1'b1, mdl[l2[11:2]]});
    for (int i = 0; i < nb; i++) begin
      ad = a + 32'(4 * i);
      d = $urandom;
      if (b && k != MBG_K_LINEFETCH)
        d = {4{d[7:0]}};
      if (k == MBG_K_SWAP || k == MBG_K_LINEFETCH || (k == MBG_K_UNCACHED && !w))
        exp_q.push_back({1'b0, mdl[ad[11:2]]});
      if (k == MBG_K_SWAP || k == MBG_K_BUFFERED || (k == MBG_K_UNCACHED && w)) begin
        wq.push_back(d);
        if (b)
          mdl[ad[11:2]][8 * ad[1:0] +: 8] = d[7:0];
        else
          mdl[ad[11:2]] = d;
      end
    end
    @(posedge clk);
    req_valid   <= 1'b1;
    req_kind    <= k;
    req_addr    <= a;
    req_count   <= 8'(n);
    req_write   <= w;
    req_byte    <= b;
    req_walk    <= wk;
    req_l1_addr <= l1;
    req_l2_addr <= l2;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask : issue

  // main sequence
  initial begin
    logic [31:0] a;
    mbg_kind_t   k;
    int          t;
    {srst, req_valid, req_write, req_byte, wdata_valid, load_en} = 6'h20;
    {req_addr, req_l1_addr, req_l2_addr, wdata, load_addr, load_data, peek_addr} = '0;
    {req_count, req_walk, bad_count, n_compared, cyc} = '0;
    req_kind = MBG_K_UNCACHED;
    void'($urandom(32'h8F99));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 1024; i++) begin
      @(posedge clk);
      mdl[i] = $urandom;
      load_en   <= 1'b1;
      load_addr <= 32'(i * 4);
      load_data <= mdl[i];
    end
    @(posedge clk);
    load_en <= 1'b0;
    issue(MBG_K_UNCACHED, 32'h3F8, 4, 1'b1, 1'b0, 2'h0);
    issue(MBG_K_UNCACHED, 32'h3F8, 4, 1'b0, 1'b0, 2'h0);
    issue(MBG_K_UNCACHED, 32'h100, 1, 1'b0, 1'b0, 2'h0);
    issue(MBG_K_UNCACHED, 32'h104, 2, 1'b1, 1'b0, 2'h0);
    issue(MBG_K_BUFFERED, 32'h200, 3, 1'b1, 1'b1, 2'h0);
    issue(MBG_K_LINEFETCH, 32'h230, 1, 1'b0, 1'b1, 2'h2);
    issue(MBG_K_SWAP, 32'h300, 1, 1'b0, 1'b0, 2'h0);
    issue(MBG_K_SWAP, 32'h304, 1, 1'b0, 1'b0, 2'h1);
    for (int i = 0; i < 200; i++) begin
      k = mbg_kind_t'($urandom % 4);
      a = $urandom % 32'hF00;
      if (k == MBG_K_LINEFETCH)
        a = a & ~32'hF;
      else if (!a[4])
        a = a & ~32'h3;
      issue(k, a, $urandom % 7, 1'($urandom), 1'(a[1:0] != 2'h0), 2'($urandom % 3));
    end
    t = 0;
    while ((exp_q.size() > 0 || busy || wq.size() > 0) && t < 2000) begin
      @(negedge clk);
      t++;
    end
    chk(33'(exp_q.size()), 33'h0);
    for (int i = 0; i < 1024; i++) begin
      @(posedge clk);
      peek_addr <= 32'(i * 4);
      @(posedge clk);
      @(negedge clk);
      chk({1'b0, peek_data}, {1'b0, mdl[i]});
    end
    print_verdict();
  end
endmodule : tb
